//--- hdl/lut_pkg.sv
// Operation
// - Upper mode 00 leaves lines 7-5 plain GPIO, and line 4 too unless lower mode is 11
// - Upper mode 01 drives line 6 from table
// - Upper mode 10 drives line 7 from table
// - Lower mode 00 leaves lines 3-0 plain GPIO
// - Lower mode 01 drives line 2 from table
// - Lower mode 10 drives line 3 from table
// - Lower mode 11 drives lines 4,3 from two tables
// - Line 6 takes two-input bit 4 plus lines 5:4
// - Line 2 takes two-input bit lines 1:0
// - Line 7 takes upper table bit lines 6:4
// - Line 3 takes lower table bit lines 2:0 in lower mode 10, table A bit in mode 11
package lut_pkg;

  localparam logic [7:0] LOGIC_MODE_SELECT_OFS        = 8'h10;
  localparam logic [7:0] TWO_INPUT_LOOKUP_OFS         = 8'h11;
  localparam logic [7:0] UPPER_THREE_INPUT_LOOKUP_OFS = 8'h12;
  localparam logic [7:0] LOWER_THREE_INPUT_LOOKUP_OFS = 8'h13;
  localparam logic [7:0] DUAL_OUTPUT_LOOKUP_A_OFS     = 8'h14;
  localparam logic [7:0] DUAL_OUTPUT_LOOKUP_B_OFS     = 8'h15;

  localparam logic [7:0] TABLE_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int UPPER_MODE_LSB = 4;
  localparam int LOWER_MODE_LSB = 0;

  localparam int UPPER_TWO_IN_LINE   = 6;
  localparam int UPPER_THREE_IN_LINE = 7;
  localparam int LOWER_TWO_IN_LINE   = 2;
  localparam int LOWER_THREE_IN_LINE = 3;
  localparam int DUAL_HIGH_LINE      = 4;

  typedef enum logic [1:0] {
    MODE_PLAIN       = 2'b00,
    MODE_TWO_TO_ONE  = 2'b01,
    MODE_THREE_TO_ONE = 2'b10,
    MODE_THREE_TO_TWO = 2'b11
  } logic_mode_t;

  localparam logic_mode_t MODE_RESET = MODE_PLAIN;

  function automatic logic lut_pick(input logic [7:0] table_bits, input logic [2:0] index);
    lut_pick = table_bits[index];
  endfunction : lut_pick

endpackage : lut_pkg

//--- hdl/reset_release.sv
module reset_release (
  input  wire logic clock,
  input  wire logic rstn,
  output logic      rst_sync_n
);

  logic first_q;
  logic second_q;

  // Assert at once, release only after two clean edges
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      first_q  <= 1'b0;
      second_q <= 1'b0;
    end else begin
      first_q  <= 1'b1;
      second_q <= first_q;
    end
  end

  assign rst_sync_n = second_q;

endmodule : reset_release

//--- hdl/pin_override.sv
module pin_override #(
  parameter int PIN_W = 8
) (
  input  wire logic [PIN_W-1:0] gpio_data,
  input  wire logic [PIN_W-1:0] gpio_dir_oe,
  input  wire logic [PIN_W-1:0] decode_en,
  input  wire logic [PIN_W-1:0] decode_val,
  output logic      [PIN_W-1:0] pin_out,
  output logic      [PIN_W-1:0] pin_oe
);

  // A decoded line is always driven, whatever its direction setting
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      pin_out[i] = decode_en[i] ? decode_val[i] : gpio_data[i];
      pin_oe[i]  = decode_en[i] | gpio_dir_oe[i];
    end
  end

endmodule : pin_override

//--- hdl/gpio_lookup_table_logic.sv
module gpio_lookup_table_logic #(
  parameter int PIN_W  = 8,
  parameter int DATA_W = 8
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [PIN_W-1:0]  pin_in,
  input  wire logic [PIN_W-1:0]  gpio_data,
  input  wire logic [PIN_W-1:0]  gpio_dir_oe,
  output logic      [PIN_W-1:0]  pin_out,
  output logic      [PIN_W-1:0]  pin_oe,
  output logic      [PIN_W-1:0]  decode_active
);
  import lut_pkg::*;

  logic rst_sync_n;

  reset_release u_reset_release (
    .clock      (clock),
    .rstn       (rstn),
    .rst_sync_n (rst_sync_n)
  );

  // Register state

  logic_mode_t       upper_mode_q;
  logic_mode_t       upper_mode_d;
  logic_mode_t       lower_mode_q;
  logic_mode_t       lower_mode_d;
  logic [7:0]        two_input_lookup_q;
  logic [7:0]        two_input_lookup_d;
  logic [7:0]        upper_three_input_lookup_q;
  logic [7:0]        upper_three_input_lookup_d;
  logic [7:0]        lower_three_input_lookup_q;
  logic [7:0]        lower_three_input_lookup_d;
  logic [7:0]        dual_output_lookup_a_q;
  logic [7:0]        dual_output_lookup_a_d;
  logic [7:0]        dual_output_lookup_b_q;
  logic [7:0]        dual_output_lookup_b_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [7:0]        read_value;

  // One address decode shared by the write and read paths
  typedef enum logic [2:0] {
    SEL_MODE   = 3'b000,
    SEL_TWO_IN = 3'b001,
    SEL_UPPER3 = 3'b010,
    SEL_LOWER3 = 3'b011,
    SEL_DUAL_A = 3'b100,
    SEL_DUAL_B = 3'b101,
    SEL_NONE   = 3'b111
  } reg_sel_t;

  function automatic reg_sel_t reg_select(input logic [7:0] addr);
    reg_sel_t sel;
    case (addr)
      LOGIC_MODE_SELECT_OFS: begin
        sel = SEL_MODE;
      end
      TWO_INPUT_LOOKUP_OFS: begin
        sel = SEL_TWO_IN;
      end
      UPPER_THREE_INPUT_LOOKUP_OFS: begin
        sel = SEL_UPPER3;
      end
      LOWER_THREE_INPUT_LOOKUP_OFS: begin
        sel = SEL_LOWER3;
      end
      DUAL_OUTPUT_LOOKUP_A_OFS: begin
        sel = SEL_DUAL_A;
      end
      DUAL_OUTPUT_LOOKUP_B_OFS: begin
        sel = SEL_DUAL_B;
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase
    return sel;
  endfunction : reg_select

  // Write path: tables keep their contents in every mode
  always_comb begin
    upper_mode_d               = upper_mode_q;
    lower_mode_d               = lower_mode_q;
    two_input_lookup_d         = two_input_lookup_q;
    upper_three_input_lookup_d = upper_three_input_lookup_q;
    lower_three_input_lookup_d = lower_three_input_lookup_q;
    dual_output_lookup_a_d     = dual_output_lookup_a_q;
    dual_output_lookup_b_d     = dual_output_lookup_b_q;
    if (reg_wr) begin
      case (reg_select(reg_addr))
        SEL_MODE: begin
          // Reserved bits 7:6 and 3:2 are not stored
          upper_mode_d = logic_mode_t'(reg_wdata[UPPER_MODE_LSB +: 2]);
          lower_mode_d = logic_mode_t'(reg_wdata[LOWER_MODE_LSB +: 2]);
        end
        SEL_TWO_IN: begin
          two_input_lookup_d = reg_wdata[7:0];
        end
        SEL_UPPER3: begin
          upper_three_input_lookup_d = reg_wdata[7:0];
        end
        SEL_LOWER3: begin
          lower_three_input_lookup_d = reg_wdata[7:0];
        end
        SEL_DUAL_A: begin
          dual_output_lookup_a_d = reg_wdata[7:0];
        end
        SEL_DUAL_B: begin
          dual_output_lookup_b_d = reg_wdata[7:0];
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Read path, registered so read data comes from a flop
  always_comb begin
    case (reg_select(reg_addr))
      SEL_MODE: begin
        read_value = {2'b00, upper_mode_q, 2'b00, lower_mode_q};
      end
      SEL_TWO_IN: begin
        read_value = two_input_lookup_q;
      end
      SEL_UPPER3: begin
        read_value = upper_three_input_lookup_q;
      end
      SEL_LOWER3: begin
        read_value = lower_three_input_lookup_q;
      end
      SEL_DUAL_A: begin
        read_value = dual_output_lookup_a_q;
      end
      SEL_DUAL_B: begin
        read_value = dual_output_lookup_b_q;
      end
      default: begin
        read_value = READ_UNMAPPED;
      end
    endcase
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = DATA_W'(read_value);
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      upper_mode_q               <= MODE_RESET;
      lower_mode_q               <= MODE_RESET;
      two_input_lookup_q         <= TABLE_RESET;
      upper_three_input_lookup_q <= TABLE_RESET;
      lower_three_input_lookup_q <= TABLE_RESET;
      dual_output_lookup_a_q     <= TABLE_RESET;
      dual_output_lookup_b_q     <= TABLE_RESET;
      rdata_q                    <= '0;
    end else begin
      upper_mode_q               <= upper_mode_d;
      lower_mode_q               <= lower_mode_d;
      two_input_lookup_q         <= two_input_lookup_d;
      upper_three_input_lookup_q <= upper_three_input_lookup_d;
      lower_three_input_lookup_q <= lower_three_input_lookup_d;
      dual_output_lookup_a_q     <= dual_output_lookup_a_d;
      dual_output_lookup_b_q     <= dual_output_lookup_b_d;
      rdata_q                    <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Decode: purely combinational from live pin levels and tables
  logic [PIN_W-1:0] decode_en;
  logic [PIN_W-1:0] decode_val;
  logic [2:0]       upper_two_index;
  logic [2:0]       upper_three_index;
  logic [2:0]       lower_two_index;
  logic [2:0]       lower_three_index;

  always_comb begin
    upper_two_index   = {1'b1, pin_in[5:4]};
    lower_two_index   = {1'b0, pin_in[1:0]};
    upper_three_index = pin_in[6:4];
    lower_three_index = pin_in[2:0];
  end

  always_comb begin
    decode_en  = '0;
    decode_val = '0;

    // Upper nibble; the reserved code behaves as plain GPIO
    case (upper_mode_q)
      MODE_PLAIN: begin
        // Lines 7-5 untouched; line 4 left to the lower nibble
      end
      MODE_TWO_TO_ONE: begin
        decode_en[UPPER_TWO_IN_LINE]  = 1'b1;
        decode_val[UPPER_TWO_IN_LINE] = lut_pick(two_input_lookup_q, upper_two_index);
      end
      MODE_THREE_TO_ONE: begin
        decode_en[UPPER_THREE_IN_LINE]  = 1'b1;
        decode_val[UPPER_THREE_IN_LINE] = lut_pick(upper_three_input_lookup_q, upper_three_index);
      end
      default: begin
        // Reserved: no decode, table ignored
      end
    endcase

    // Lower nibble
    case (lower_mode_q)
      MODE_PLAIN: begin
        // Lines 3-0 untouched
      end
      MODE_TWO_TO_ONE: begin
        decode_en[LOWER_TWO_IN_LINE]  = 1'b1;
        decode_val[LOWER_TWO_IN_LINE] = lut_pick(two_input_lookup_q, lower_two_index);
      end
      MODE_THREE_TO_ONE: begin
        decode_en[LOWER_THREE_IN_LINE]  = 1'b1;
        decode_val[LOWER_THREE_IN_LINE] = lut_pick(lower_three_input_lookup_q, lower_three_index);
      end
      MODE_THREE_TO_TWO: begin
        // Line 3 from table A, line 4 from table B
        decode_en[LOWER_THREE_IN_LINE]  = 1'b1;
        decode_val[LOWER_THREE_IN_LINE] = lut_pick(dual_output_lookup_a_q, lower_three_index);
        decode_en[DUAL_HIGH_LINE]       = 1'b1;
        decode_val[DUAL_HIGH_LINE]      = lut_pick(dual_output_lookup_b_q, lower_three_index);
      end
      default: begin
        // Unreachable: every lower code is decoded above
      end
    endcase
  end

  // Only enabled lines reach the pins, so idle tables never leak out
  pin_override #(
    .PIN_W (PIN_W)
  ) u_pin_override (
    .gpio_data   (gpio_data),
    .gpio_dir_oe (gpio_dir_oe),
    .decode_en   (decode_en),
    .decode_val  (decode_val),
    .pin_out     (pin_out),
    .pin_oe      (pin_oe)
  );

  assign decode_active = decode_en;

endmodule : gpio_lookup_table_logic

//--- testbench/lut_assertions.sv
module lut_assertions #(
  parameter int PIN_W  = 8,
  parameter int DATA_W = 8
) (
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic [7:0]        reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [PIN_W-1:0]  gpio_data,
  input wire logic [PIN_W-1:0]  pin_out,
  input wire logic [PIN_W-1:0]  pin_oe,
  input wire logic [PIN_W-1:0]  decode_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence mode_wr;
    reg_wr && reg_addr == 8'h10;
  endsequence
  sequence tbl_wr_rd;
    reg_wr && reg_addr == 8'h11 ##1 reg_rd && !reg_wr && reg_addr == 8'h11;
  endsequence
  a_upper_plain: assert property (mode_wr ##0 reg_wdata[5:4] == 2'b00 |=> decode_active[7:5] == 3'b000)
    else $error("upper lines decoded in plain mode");
  a_upper_two: assert property (mode_wr ##0 reg_wdata[5:4] == 2'b01 |=> decode_active[7:6] == 2'b01)
    else $error("line 6 not decoded");
  a_upper_three: assert property (mode_wr ##0 reg_wdata[5:4] == 2'b10 |=> decode_active[7:6] == 2'b10)
    else $error("line 7 not decoded");
  a_lower_plain: assert property (mode_wr ##0 reg_wdata[1:0] == 2'b00 |=> decode_active[3:0] == 4'h0)
    else $error("lower lines decoded in plain mode");
  a_lower_two: assert property (mode_wr ##0 reg_wdata[1:0] == 2'b01 |=> decode_active[3:2] == 2'b01)
    else $error("line 2 not decoded");
  a_lower_three: assert property (mode_wr ##0 reg_wdata[1:0] == 2'b10 |=> decode_active[3:2] == 2'b10)
    else $error("line 3 not decoded");
  a_dual_out: assert property (mode_wr ##0 reg_wdata[1:0] == 2'b11 |=> decode_active[4:2] == 3'b110)
    else $error("lines 4 and 3 not decoded");
  a_decode_drives: assert property ((pin_oe & decode_active) == decode_active)
    else $error("decoded line not driven");
  a_plain_follow: assert property (((pin_out ^ gpio_data) & ~decode_active) == '0)
    else $error("plain line differs from gpio data");
  a_table_kept: assert property (tbl_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("table read back differs");
endmodule : lut_assertions

bind gpio_lookup_table_logic lut_assertions #(.PIN_W(PIN_W), .DATA_W(DATA_W)) u_chk (
  .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_data(gpio_data), .pin_out(pin_out),
  .pin_oe(pin_oe), .decode_active(decode_active));

//--- testbench/pin_pad_model.sv
module pin_pad_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Outside circuit drives every line the device leaves alone
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_pad_model

//--- testbench/gpio_lookup_table_logic_tb.sv
module gpio_lookup_table_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, rstn, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_in, gpio_data, gpio_dir_oe;
  logic [7:0] pin_out, pin_oe, decode_active, ext_level;
  int         err_count = 0, total_checks = 0, cyc = 0;

  gpio_lookup_table_logic u_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .gpio_data(gpio_data),
    .gpio_dir_oe(gpio_dir_oe), .pin_out(pin_out), .pin_oe(pin_oe), .decode_active(decode_active));
  pin_pad_model u_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Strobes stay up until the next task, so no signal is set twice in one step
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_rd    = 1'b0;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clock);
    #2;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd   = 1'b1;
    reg_wr   = 1'b0;
    reg_addr = a;
    @(posedge clock);
    #2;
    check("reg_rdata", reg_rdata, exp);
  endtask : rd
  task idle;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge clock);
    #2;
  endtask : idle
  task sweep(input int line, input int lsb, input int n, input int off, input logic [7:0] tbl);
    for (int v = 0; v < (1 << n); v++) begin
      @(posedge clock);
      #2;
      ext_level = 8'(v << lsb);
      #1;
      check("pin_out", 8'(pin_out[line]), 8'(tbl[off + v]));
      check("pin_oe", 8'(pin_oe[line]), 8'h01);
    end
  endtask : sweep

  task t_regs;
    rd(8'h10, 8'h00);
    rd(8'h12, 8'h00);
    wr(8'h13, 8'h3c);
    wr(8'h16, 8'hff);
    rd(8'h16, 8'h00);
    rd(8'h13, 8'h3c);
  endtask : t_regs
  task t_upper;
    wr(8'h11, 8'h5a);
    rd(8'h11, 8'h5a);
    wr(8'h10, 8'h10);
    idle();
    check("decode_active", decode_active, 8'h40);
    sweep(6, 4, 2, 4, 8'h5a);
    wr(8'h12, 8'h96);
    wr(8'h10, 8'h20);
    idle();
    sweep(7, 4, 3, 0, 8'h96);
  endtask : t_upper
  task t_lower;
    wr(8'h10, 8'h01);
    idle();
    sweep(2, 0, 2, 0, 8'h5a);
    wr(8'h10, 8'h02);
    idle();
    sweep(3, 0, 3, 0, 8'h3c);
    wr(8'h14, 8'hc3);
    wr(8'h15, 8'h69);
    wr(8'h10, 8'h03);
    idle();
    sweep(3, 0, 3, 0, 8'hc3);
    sweep(4, 0, 3, 0, 8'h69);
  endtask : t_lower
  task t_plain;
    gpio_dir_oe = 8'hff;
    gpio_data = 8'ha5;
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h33);
    idle();
    check("decode_active", decode_active, 8'h18);
    wr(8'h10, 8'h00);
    idle();
    check("pin_out", pin_out, 8'ha5);
    check("pin_oe", pin_oe, 8'hff);
    check("decode_active", decode_active, 8'h00);
  endtask : t_plain

  initial begin
    rstn        = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    gpio_data   = 8'h00;
    gpio_dir_oe = 8'h00;
    ext_level   = 8'h00;
    repeat (5) @(posedge clock);
    #2 rstn = 1'b1;
    repeat (3) @(posedge clock);
    #2;
    t_regs();
    t_upper();
    t_lower();
    t_plain();
    close_out();
  end
endmodule : gpio_lookup_table_logic_tb
